// ### include/cmp_pkg.sv
// Shared constants, states and address helpers of the compass serial port.
package cmp_pkg;

  // Fixed upper part of the 7-bit bus address; the low two bits are pins.
  localparam logic [4:0] DEV_ADDR_HI = 5'h07;

  // Register groups; burst access wraps inside each group.
  localparam logic [7:0] RO_FIRST = 8'hC0;
  localparam logic [7:0] RO_LAST = 8'hC4;
  localparam logic [7:0] RW_FIRST = 8'hE0;
  localparam logic [7:0] RW_LAST = 8'hE6;

  // Result registers whose read clears the measurement-done state.
  localparam logic [7:0] RES_FIRST = 8'hC1;
  localparam logic [7:0] RES_LAST = 8'hC4;

  // Only this register may be written while a measurement runs.
  localparam logic [7:0] MODE_REG_ADDR = 8'hE0;

  // Address counter value after reset.
  localparam logic [7:0] ADDR_CNT_RST = 8'hC0;

  // Bit counts within a byte.
  localparam logic [3:0] BYTE_LEN = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK_A = 3'b010,
    ST_WREG = 3'b011,
    ST_ACK_W = 3'b100,
    ST_WDATA = 3'b101,
    ST_TX = 3'b110,
    ST_RACK = 3'b111
  } cmp_state_t;

  // Next counter value, wrapping inside the two register groups.
  function automatic logic [7:0] next_addr(input logic [7:0] a);
    if (a == RO_LAST) begin
      next_addr = RO_FIRST;
    end else if (a == RW_LAST) begin
      next_addr = RW_FIRST;
    end else begin
      next_addr = a + 8'h01;
    end
  endfunction

  // True for the measurement result registers.
  function automatic logic is_result(input logic [7:0] a);
    is_result = (a >= RES_FIRST) && (a <= RES_LAST);
  endfunction

endpackage

// ### hdl/cmp_i2c_slave.sv
// Serial bus slave port of the compass sensor, with register bank handshake.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Works at bus clock rates up to 100 kHz and 400 kHz.
// - After start, acknowledge and act only when the address byte matches.
// - Data line changes only while the bus clock is low.
// - Data fall with clock high is start; data rise with clock high is stop.
// - Transmitter releases data after eight bits; receiver pulls low ninth.
// - In writes, acknowledge address byte, register address and every data.
// - In reads, sample master acknowledge; send next byte or stop sending.
// - Bus address is fixed five bits plus two address-select pins.
// - Last bit of the address byte: one reads, zero writes.
// - Second write byte, MSB first, loads the address counter.
// - Later write bytes are MSB-first data; master ends with a stop.
// - Each further written byte goes to the next register address.
// - Burst writes wrap from the last writable to the first writable.
// - Burst reads wrap inside the read-only or the writable group.
// - Address counter holds one past the last accessed register.
// - Current-address read sends the counter's byte, then increments.
// - Random read sends the supplied address's byte, then increments.
// - Twelve byte registers are reached through this port.
// - During measurement only the mode register may be written.
// - Reading a result register clears measurement-done interrupt and flag.
module cmp_i2c_slave (
  // System clock domain.
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Link sampling clock domain.
  input wire logic link_clk,
  // Bus pins, open drain.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_select_pins,
  // Register bank side.
  output logic [7:0] bank_addr,
  output logic [7:0] bank_wdata,
  output logic bank_wr,
  output logic bank_rd,
  input wire logic [7:0] bank_rdata,
  input wire logic meas_mode,
  output logic result_read
);

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] sel_s1;
    logic [1:0] sel_s2;
    logic [1:0] en_s;
    logic scl_q;
    logic sda_q;
    logic [2:0] ack_s;
    cmp_pkg::cmp_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] addr_cnt;
    logic rw;
    logic mack;
    logic drive;
    logic req_tgl;
    logic req_wr;
    logic [7:0] req_addr;
    logic [7:0] req_data;
    logic [7:0] rdata;
  } cmp_link_t;

  typedef struct packed {
    logic [2:0] req_s;
    logic ack_tgl;
    logic pend;
    logic [7:0] bank_addr;
    logic [7:0] bank_wdata;
    logic bank_wr;
    logic bank_rd;
    logic result_read;
    logic [7:0] rd_hold;
  } cmp_sys_t;

  cmp_link_t lk_reg;
  cmp_link_t lk_next;
  cmp_sys_t sy_reg;
  cmp_sys_t sy_next;

  // Link domain: pins are sampled here at a rate far above the bus clock,
  // so both bus speeds are followed with many samples per bit.
  always_comb begin
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic match;
    lk_next = lk_reg;
    // Two-stage synchronisers read at the second stage; the answer toggle has three stages and compares its last two.
    lk_next.scl_s = {lk_reg.scl_s[0], scl_in};
    lk_next.sda_s = {lk_reg.sda_s[0], sda_in};
    lk_next.sel_s1 = addr_select_pins;
    lk_next.sel_s2 = lk_reg.sel_s1;
    lk_next.ack_s = {lk_reg.ack_s[1:0], sy_reg.ack_tgl};
    lk_next.en_s = {lk_reg.en_s[0], clk_en};
    scl = lk_reg.scl_s[1];
    sda = lk_reg.sda_s[1];
    lk_next.scl_q = scl;
    lk_next.sda_q = sda;
    rise = scl && !lk_reg.scl_q;
    fall = !scl && lk_reg.scl_q;
    start = scl && lk_reg.scl_q && lk_reg.sda_q && !sda;
    stop = scl && lk_reg.scl_q && !lk_reg.sda_q && sda;
    match = lk_reg.shreg[7:1] == {cmp_pkg::DEV_ADDR_HI, lk_reg.sel_s2};
    // Read data is taken only once the answer toggle has crossed over.
    if (lk_reg.ack_s[2] != lk_reg.ack_s[1]) begin
      lk_next.rdata = sy_reg.rd_hold;
    end
    if (start) begin
      // A repeated start keeps the address counter for random reads.
      lk_next.st = cmp_pkg::ST_ADDR;
      lk_next.bitcnt = 4'h0;
      lk_next.drive = 1'b0;
    end else if (stop) begin
      lk_next.st = cmp_pkg::ST_IDLE;
      lk_next.drive = 1'b0;
    end else begin
      case (lk_reg.st)
        cmp_pkg::ST_ADDR,
        cmp_pkg::ST_WREG,
        cmp_pkg::ST_WDATA: begin
          if (rise) begin
            lk_next.shreg = {lk_reg.shreg[6:0], sda};
            lk_next.bitcnt = lk_reg.bitcnt + 4'h1;
          end else if (fall && lk_reg.bitcnt == cmp_pkg::BYTE_LEN) begin
            lk_next.bitcnt = 4'h0;
            if (lk_reg.st == cmp_pkg::ST_ADDR) begin
              if (match) begin
                lk_next.drive = 1'b1;
                lk_next.st = cmp_pkg::ST_ACK_A;
                lk_next.rw = lk_reg.shreg[0];
                if (lk_reg.shreg[0]) begin
                  // Fetch now so the byte is ready when the ack ends.
                  lk_next.req_tgl = !lk_reg.req_tgl;
                  lk_next.req_wr = 1'b0;
                  lk_next.req_addr = lk_reg.addr_cnt;
                  lk_next.addr_cnt = cmp_pkg::next_addr(lk_reg.addr_cnt);
                end
              end else begin
                lk_next.st = cmp_pkg::ST_IDLE;
              end
            end else if (lk_reg.st == cmp_pkg::ST_WREG) begin
              lk_next.addr_cnt = lk_reg.shreg;
              lk_next.drive = 1'b1;
              lk_next.st = cmp_pkg::ST_ACK_W;
            end else begin
              lk_next.req_tgl = !lk_reg.req_tgl;
              lk_next.req_wr = 1'b1;
              lk_next.req_addr = lk_reg.addr_cnt;
              lk_next.req_data = lk_reg.shreg;
              lk_next.addr_cnt = cmp_pkg::next_addr(lk_reg.addr_cnt);
              lk_next.drive = 1'b1;
              lk_next.st = cmp_pkg::ST_ACK_W;
            end
          end
        end
        cmp_pkg::ST_ACK_A: begin
          if (fall) begin
            if (lk_reg.rw) begin
              lk_next.shreg = lk_reg.rdata;
              lk_next.drive = !lk_reg.rdata[7];
              lk_next.st = cmp_pkg::ST_TX;
            end else begin
              lk_next.drive = 1'b0;
              lk_next.st = cmp_pkg::ST_WREG;
            end
          end
        end
        cmp_pkg::ST_ACK_W: begin
          if (fall) begin
            lk_next.drive = 1'b0;
            lk_next.st = cmp_pkg::ST_WDATA;
          end
        end
        cmp_pkg::ST_TX: begin
          if (fall) begin
            if (lk_reg.bitcnt == cmp_pkg::LAST_BIT) begin
              lk_next.drive = 1'b0;
              lk_next.st = cmp_pkg::ST_RACK;
            end else begin
              lk_next.shreg = {lk_reg.shreg[6:0], 1'b0};
              lk_next.drive = !lk_reg.shreg[6];
              lk_next.bitcnt = lk_reg.bitcnt + 4'h1;
            end
          end
        end
        cmp_pkg::ST_RACK: begin
          if (rise) begin
            lk_next.mack = !sda;
            if (!sda) begin
              lk_next.req_tgl = !lk_reg.req_tgl;
              lk_next.req_wr = 1'b0;
              lk_next.req_addr = lk_reg.addr_cnt;
              lk_next.addr_cnt = cmp_pkg::next_addr(lk_reg.addr_cnt);
            end
          end else if (fall) begin
            lk_next.bitcnt = 4'h0;
            if (lk_reg.mack) begin
              lk_next.shreg = lk_reg.rdata;
              lk_next.drive = !lk_reg.rdata[7];
              lk_next.st = cmp_pkg::ST_TX;
            end else begin
              lk_next.st = cmp_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          lk_next.drive = 1'b0;
        end
      endcase
    end
    // While the enable is low the link side holds still; only the
    // enable's own synchroniser keeps moving so that it can wake up.
    if (!lk_reg.en_s[1]) begin
      lk_next = lk_reg;
      lk_next.en_s = {lk_reg.en_s[0], clk_en};
    end
  end

  // Reset leaves both bus lines seen as high, so that the first samples
  // after release cannot look like a start or a stop.
  // The enable synchroniser starts low, which holds the link side for two
  // sampling clocks after release; the bus is quiet then in any case.
  // A bus master that is halfway through a transfer when reset falls sees
  // the data line released and will find no acknowledge; it must begin
  // again with a start, as after any other lost transfer.

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      lk_reg <= '{
        scl_s: 2'h3,
        sda_s: 2'h3,
        sel_s1: 2'h0,
        sel_s2: 2'h0,
        en_s: 2'h0,
        scl_q: 1'b1,
        sda_q: 1'b1,
        ack_s: 3'h0,
        st: cmp_pkg::ST_IDLE,
        bitcnt: 4'h0,
        shreg: 8'h00,
        addr_cnt: cmp_pkg::ADDR_CNT_RST,
        rw: 1'b0,
        mack: 1'b0,
        drive: 1'b0,
        req_tgl: 1'b0,
        req_wr: 1'b0,
        req_addr: 8'h00,
        req_data: 8'h00,
        rdata: 8'h00
      };
    end else begin
      lk_reg <= lk_next;
    end
  end

  // System domain: turns each crossed request, except a dropped write, into one bank strobe.
  // Request words are stable while the toggle travels, so they are safe
  // to take once the toggle has been seen.
  always_comb begin
    sy_next = sy_reg;
    sy_next.req_s = {sy_reg.req_s[1:0], lk_reg.req_tgl};
    sy_next.bank_wr = 1'b0;
    sy_next.bank_rd = 1'b0;
    sy_next.result_read = 1'b0;
    if (sy_reg.pend) begin
      sy_next.rd_hold = bank_rdata;
      sy_next.ack_tgl = !sy_reg.ack_tgl;
      sy_next.pend = 1'b0;
    end else if (sy_reg.req_s[2] != sy_reg.req_s[1]) begin
      if (lk_reg.req_wr) begin
        // Writes to other registers are dropped during a measurement; the
        // bank outputs then keep the last request, so nothing moves.
        if (!meas_mode || lk_reg.req_addr == cmp_pkg::MODE_REG_ADDR) begin
          sy_next.bank_addr = lk_reg.req_addr;
          sy_next.bank_wdata = lk_reg.req_data;
          sy_next.bank_wr = 1'b1;
        end
        sy_next.ack_tgl = !sy_reg.ack_tgl;
      end else begin
        sy_next.bank_addr = lk_reg.req_addr;
        sy_next.bank_rd = 1'b1;
        sy_next.result_read = cmp_pkg::is_result(lk_reg.req_addr);
        sy_next.pend = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sy_reg <= '{
        req_s: 3'h0,
        ack_tgl: 1'b0,
        pend: 1'b0,
        bank_addr: 8'h00,
        bank_wdata: 8'h00,
        bank_wr: 1'b0,
        bank_rd: 1'b0,
        result_read: 1'b0,
        rd_hold: 8'h00
      };
    end else if (clk_en) begin
      sy_reg <= sy_next;
    end
  end

  // The data pin is open drain: the port only ever pulls low, and the
  // enable alone says whether it does so.
  // The enable comes straight from a flip-flop of the link side, so it
  // cannot glitch while the bus clock is high.
  // Bank strobes last one system clock each and never overlap, because a
  // new request is taken only after the last one has been answered.
  // The bank address and data stand from one request to the next, which
  // lets a bank decode them at leisure.
  // A read answer is taken one system clock after the read strobe, so the
  // bank may decode its read data straight from the address.
  assign sda_out = 1'b0;
  assign sda_oe = lk_reg.drive;
  assign bank_addr = sy_reg.bank_addr;
  assign bank_wdata = sy_reg.bank_wdata;
  assign bank_wr = sy_reg.bank_wr;
  assign bank_rd = sy_reg.bank_rd;
  assign result_read = sy_reg.result_read;

endmodule
`default_nettype wire

// ### testbench/cmp_i2c_slave_monitor.sv
// Assertions on the ports of the compass serial port.
`timescale 1ns/1ns
`default_nettype none
module cmp_i2c_slave_monitor (
  // Clocks and reset.
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  // Bus and bank signals.
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [7:0] bank_addr,
  input wire logic bank_wr,
  input wire logic bank_rd,
  input wire logic meas_mode,
  input wire logic result_read
);
  logic is_res;
  assign is_res = (bank_addr >= 8'hC1) && (bank_addr <= 8'hC4);
  sequence s_no_wr;
    !bank_wr [*8];
  endsequence
  sequence s_no_rd;
    !bank_rd [*8];
  endsequence
  chk_oe_scl_low:
    assert property (@(posedge link_clk) disable iff (!reset_n)
      $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("data drive changed with bus clock high");
  chk_drive_low:
    assert property (@(posedge link_clk) disable iff (!reset_n)
      sda_out == 1'b0) else $error("data pin driven high");
  chk_wr_gap:
    assert property (@(posedge clk) disable iff (!reset_n)
      bank_wr |=> s_no_wr) else $error("write strobes too close");
  chk_rd_gap:
    assert property (@(posedge clk) disable iff (!reset_n)
      bank_rd |=> s_no_rd) else $error("read strobes too close");
  chk_rd_wr_excl:
    assert property (@(posedge clk) disable iff (!reset_n)
      bank_rd |-> !bank_wr) else $error("read and write together");
  chk_res_pulse:
    assert property (@(posedge clk) disable iff (!reset_n)
      result_read |-> bank_rd && is_res) else $error("stray result read");
  chk_res_needed:
    assert property (@(posedge clk) disable iff (!reset_n)
      bank_rd && is_res |-> result_read) else $error("result read missed");
  chk_meas_write:
    assert property (@(posedge clk) disable iff (!reset_n)
      bank_wr && meas_mode |-> bank_addr == 8'hE0)
    else $error("write during measurement");
  chk_addr_hold:
    assert property (@(posedge clk) disable iff (!reset_n)
      !bank_wr && !bank_rd |-> $stable(bank_addr))
    else $error("address moved without a request");
endmodule
bind cmp_i2c_slave cmp_i2c_slave_monitor i_cmp_i2c_slave_monitor (.clk,
  .reset_n, .link_clk, .scl_in, .sda_out, .sda_oe, .bank_addr, .bank_wr,
  .bank_rd, .meas_mode, .result_read);
`default_nettype wire

// ### testbench/cmp_host.sv
// Serial bus master model that clocks the bus and moves bytes.
`timescale 1ns/1ns
`default_nettype none
module cmp_host (
  // Pacing reference.
  input wire logic clk,
  // Bus lines.
  input wire logic sda_in,
  output logic scl_in,
  output logic sda_low
);
  // Four quarters of 7 cycles give a 2.8 us bit, inside the fast limit.
  localparam int QTR = 7;
  initial begin
    scl_in = 1'b1;
    sda_low = 1'b0;
  end
  task automatic step(input logic c, input logic s);
    scl_in <= c;
    sda_low <= s;
    repeat (QTR) @(posedge clk);
  endtask
  // Also serves as a repeated start, since the clock is low between bytes.
  task automatic start();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask
  task automatic stop();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  task automatic bit_io(input logic b, output logic r);
    step(1'b0, !b);
    step(1'b1, !b);
    r = sda_in;
    step(1'b1, !b);
    step(1'b0, !b);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // A low answer asks for another byte; a high one ends the read.
  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(!ack, r);
  endtask
endmodule
`default_nettype wire

// ### testbench/cmp_i2c_slave_tb.sv
// Self-checking bench for the compass serial port.
`timescale 1ns/1ns
`default_nettype none
module cmp_i2c_slave_tb;
  logic clk, link_clk, reset_n, meas_mode, scl_in, sda_low, sda_in;
  logic sda_out, sda_oe, bank_wr, bank_rd, result_read;
  logic [1:0] addr_select_pins;
  logic [7:0] bank_addr, bank_wdata, bank_rdata, rd_n, rr_n;
  logic [7:0] mem [256];
  int err_count, total_checks, cycles;
  // Open-drain line: the pull-up wins unless someone pulls low.
  assign sda_in = !(sda_low || (sda_oe && !sda_out));
  assign bank_rdata = mem[bank_addr];
  function automatic logic [7:0] pat(input logic [7:0] a);
    pat = a ^ 8'hA5;
  endfunction
  function automatic logic [7:0] dev(input logic [1:0] s, input logic rw);
    dev = {5'h07, s, rw};
  endfunction
  initial begin
    clk = 1'b0;
    forever #50 clk = !clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = !link_clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    rd_n <= rd_n + {7'h00, bank_rd};
    rr_n <= rr_n + {7'h00, result_read};
    if (bank_wr) begin
      mem[bank_addr] <= bank_wdata;
    end
    if (cycles == 40000) begin
      err_count++;
      $display("unexpected at %0t: timeout", $time);
      close_out();
    end
  end
  cmp_i2c_slave i_cmp_i2c_slave (.clk, .reset_n, .clk_en(1'b1), .link_clk,
    .scl_in, .sda_in, .sda_out, .sda_oe, .addr_select_pins, .bank_addr,
    .bank_wdata, .bank_wr, .bank_rd, .bank_rdata, .meas_mode, .result_read);
  cmp_host i_cmp_host (.clk, .sda_in, .scl_in, .sda_low);
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tx(input logic [7:0] d, input logic exp);
    logic a;
    i_cmp_host.send(d, a);
    check({7'h00, a}, {7'h00, exp});
  endtask
  task automatic rx(input logic ack, input logic [7:0] exp);
    logic [7:0] d;
    i_cmp_host.recv(ack, d);
    check(d, exp);
  endtask
  task automatic sc_write_burst();
    i_cmp_host.start();
    tx(dev(2'b10, 1'b0), 1'b1);
    tx(8'hE5, 1'b1);
    tx(8'h11, 1'b1);
    tx(8'h22, 1'b1);
    tx(8'h33, 1'b1);
    i_cmp_host.stop();
    check(mem[8'hE5], 8'h11);
    check(mem[8'hE6], 8'h22);
    check(mem[8'hE0], 8'h33);
  endtask
  task automatic sc_cur_read();
    logic [7:0] n;
    n = rd_n;
    i_cmp_host.start();
    tx(dev(2'b10, 1'b1), 1'b1);
    rx(1'b1, pat(8'hE1));
    rx(1'b0, pat(8'hE2));
    i_cmp_host.stop();
    check(rd_n - n, 8'h02);
  endtask
  task automatic sc_rand_read();
    logic [7:0] n;
    n = rr_n;
    i_cmp_host.start();
    tx(dev(2'b10, 1'b0), 1'b1);
    tx(8'hC3, 1'b1);
    i_cmp_host.start();
    tx(dev(2'b10, 1'b1), 1'b1);
    rx(1'b1, pat(8'hC3));
    rx(1'b1, pat(8'hC4));
    rx(1'b0, pat(8'hC0));
    i_cmp_host.stop();
    i_cmp_host.start();
    tx(dev(2'b10, 1'b1), 1'b1);
    rx(1'b0, pat(8'hC1));
    i_cmp_host.stop();
    check(rr_n - n, 8'h03);
  endtask
  task automatic sc_mismatch();
    for (int i = 0; i < 4; i++) begin
      i_cmp_host.start();
      tx(dev(2'(i), 1'b0), i == 2);
      tx(8'hE3, i == 2);
      i_cmp_host.stop();
    end
  endtask
  task automatic sc_meas();
    meas_mode <= 1'b1;
    i_cmp_host.start();
    tx(dev(2'b10, 1'b0), 1'b1);
    tx(8'hE0, 1'b1);
    tx(8'h0C, 1'b1);
    tx(8'h5F, 1'b1);
    i_cmp_host.stop();
    meas_mode <= 1'b0;
    check(mem[8'hE0], 8'h0C);
    check(mem[8'hE1], pat(8'hE1));
  endtask
  task automatic close_out();
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    meas_mode = 1'b0;
    addr_select_pins = 2'b10;
    err_count = 0;
    total_checks = 0;
    cycles = 0;
    rd_n = 8'h00;
    rr_n = 8'h00;
    for (int i = 0; i < 256; i++) begin
      mem[i] = pat(8'(i));
    end
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    sc_write_burst();
    sc_cur_read();
    sc_rand_read();
    sc_mismatch();
    sc_meas();
    close_out();
  end
endmodule
`default_nettype wire
